// File: src/tbp_port.v
// Two-bit bidirectional port with pulldown control and register access
//
// Function
// - Two external pins, each software programmable as input or output.
// - Each pin has a read/write data latch untouched by reset.
// - Direction bit one selects output, zero selects input.
// - Reset clears all direction bits so pins start as inputs.
// - Direction one enables the output driver; zero turns the driver off.
// - Data read of an output pin returns its latch.
// - Data read of an input pin returns the pin level.
// - Data writes always load latches; inputs are unaffected.
// - Input pins get a pulldown unless inhibited.
// - Inhibit one disables the pulldown, zero keeps it.
// - Reset loads both external inhibit bits from the reset option.
// - With reset option set, reset leaves external inputs with pulldowns off.
// - Bits 5, 4, 1, 0 read/write but have no pins.
// - Internal bits always pulled down as inputs, no inhibit control.
//
// Strobed register access is this design's own decision.
`include "tbp_map.vh"

module tbp_port #(
    parameter AW = 8
) (
    // Clock, enable and reset
    input wire clk,
    input wire ce,
    input wire sys_rst,
    // Reset-time option
    input wire reset_pulldown_disable_option,
    // Register port
    input wire [AW-1:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output wire [7:0] rdata,
    // External pins
    input wire [1:0] pin_in,
    output wire [1:0] pin_out,
    output wire [1:0] pin_oe,
    output wire [1:0] pin_pulldown_en
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function hit;
        input [AW-1:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs[AW-1:0]);
        end
    endfunction

    wire data_sel = hit(addr, `TBP_OFS_DATA);
    wire dir_sel = hit(addr, `TBP_OFS_DIR);
    wire pull_sel = hit(addr, `TBP_OFS_PULL);

    wire [`TBP_IMPL_BITS-1:0] rd_bits;
    wire [`TBP_IMPL_BITS-1:0] dir_bits;
    wire [`TBP_IMPL_BITS-1:0] drv_bits;
    wire [`TBP_IMPL_BITS-1:0] pd_bits;
    reg [7:0] rdata_reg;
    reg [7:0] rdata_next;

    // ----------------------------------------
    // Bit cells
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < `TBP_IMPL_BITS; i = i + 1) begin : g_bit
            localparam EXT = (i >= `TBP_EXT_LO) && (i <= `TBP_EXT_HI);
            wire lvl;
            if (EXT) begin : g_ext
                assign lvl = pin_in[i-`TBP_EXT_LO];
            end else begin : g_int
                // No pin: the permanent pulldown holds it low
                assign lvl = 1'b0;
            end
            tbp_bit #(
                .HAS_INH(EXT ? 1 : 0)
            ) u_bit (
                .clk(clk),
                .ce(ce),
                .sys_rst(sys_rst),
                .data_we(wr & data_sel),
                .dir_we(wr & dir_sel),
                .inh_we(wr & pull_sel),
                .wbit(wdata[i]),
                .inh_rst_val(reset_pulldown_disable_option),
                .pin_level(lvl),
                .drive_en(dir_bits[i]),
                .drive_val(drv_bits[i]),
                .pulldown_en(pd_bits[i]),
                .read_bit(rd_bits[i])
            );
        end
    endgenerate

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Inhibit register is write-only, so it reads as zero
    always @* begin
        rdata_next = 8'h00;
        if (rd) begin
            if (data_sel) begin
                rdata_next = {`TBP_UNIMPL_RD, rd_bits};
            end else if (dir_sel) begin
                rdata_next = {`TBP_UNIMPL_RD, dir_bits};
            end
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (ce) begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;

    // ----------------------------------------
    // Pin outputs
    // ----------------------------------------
    assign pin_oe = dir_bits[`TBP_EXT_HI:`TBP_EXT_LO];
    assign pin_out = drv_bits[`TBP_EXT_HI:`TBP_EXT_LO];
    assign pin_pulldown_en = pd_bits[`TBP_EXT_HI:`TBP_EXT_LO];

endmodule

// File: src/tbp_map.vh
// Register offsets, field positions and reset values of the two-bit port
`ifndef TBP_MAP_VH
`define TBP_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TBP_OFS_DATA 8'h01
`define TBP_OFS_DIR 8'h05
`define TBP_OFS_PULL 8'h11

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TBP_EXT_LO 2
`define TBP_EXT_HI 3
`define TBP_IMPL_BITS 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TBP_DIR_RST 1'b0
`define TBP_UNIMPL_RD 2'h0

`endif

// File: src/tbp_bit.v
// One bit position of the port: latch, direction and pulldown inhibit
`include "tbp_map.vh"

module tbp_bit #(
    parameter HAS_INH = 0
) (
    // Clock and reset
    input wire clk,
    input wire ce,
    input wire sys_rst,
    // Write side
    input wire data_we,
    input wire dir_we,
    input wire inh_we,
    input wire wbit,
    input wire inh_rst_val,
    // Pin side
    input wire pin_level,
    output wire drive_en,
    output wire drive_val,
    output wire pulldown_en,
    // Read side
    output wire read_bit
);

    reg latch_reg;
    reg dir_reg;
    reg inh_reg;

    // ----------------------------------------
    // Data latch
    // ----------------------------------------
    // No reset: contents survive every reset
    always @(posedge clk) begin
        if (ce && data_we) begin
            latch_reg <= wbit;
        end
    end

    // ----------------------------------------
    // Direction and inhibit
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            dir_reg <= `TBP_DIR_RST;
        end else if (ce && dir_we) begin
            dir_reg <= wbit;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            inh_reg <= (HAS_INH != 0) ? inh_rst_val : 1'b0;
        end else if (ce && inh_we && (HAS_INH != 0)) begin
            inh_reg <= wbit;
        end
    end

    // ----------------------------------------
    // Pin and read behaviour
    // ----------------------------------------
    assign drive_en = dir_reg;
    // Gated so the unreset latch never shows on an undriven pin
    assign drive_val = latch_reg & dir_reg;
    // Internal positions ignore inhibit entirely
    assign pulldown_en = ~dir_reg & ~inh_reg;
    assign read_bit = dir_reg ? latch_reg : pin_level;

endmodule

// File: test/tbp_board.sv
// Board model driving and sensing the two external pins
module tbp_board (
    input wire clk,
    input wire [1:0] out, oe, pd, ext_en, ext_val,
    output wire [1:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [1:0] flt_reg = 2'h1;
    always @(posedge clk) flt_reg <= ~flt_reg;
    // Unpulled, undriven pins wander
    assign pin = oe & out | ~oe & (ext_en & ext_val | ~ext_en & ~pd & flt_reg);
endmodule

// File: test/tbp_port_props.sv
// Assertions on the pins and register port of the two-bit port
`include "tbp_map.vh"
module tbp_props #(parameter AW = 8) (
    input wire clk, ce, sys_rst, reset_pulldown_disable_option, wr, rd,
    input wire [AW-1:0] addr,
    input wire [7:0] wdata, rdata,
    input wire [1:0] pin_in, pin_out, pin_oe, pin_pulldown_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire w_dir = wr && ce && addr == `TBP_OFS_DIR;
    wire w_dat = wr && ce && addr == `TBP_OFS_DATA;
    wire w_pul = wr && ce && addr == `TBP_OFS_PULL;
    a_oe_reset: assert property ($fell(sys_rst) |-> !pin_oe)
        else $error("oe after reset");
    a_pd_reset: assert property ($fell(sys_rst) |->
        pin_pulldown_en == {2{!$past(reset_pulldown_disable_option)}})
        else $error("pulldown after reset");
    a_dir_oe: assert property (w_dir |=>
        pin_oe == $past(wdata[3:2])) else $error("direction");
    a_out_latch: assert property (w_dat |=>
        (pin_out & pin_oe) == ($past(wdata[3:2]) & pin_oe))
        else $error("latch drive");
    a_pd_excl: assert property ((pin_oe & pin_pulldown_en) == 2'h0)
        else $error("pulldown on output");
    a_pd_inh: assert property (w_pul |=>
        pin_pulldown_en == (~$past(wdata[3:2]) & ~pin_oe))
        else $error("inhibit");
    a_rd_pins: assert property ($past(rd && ce && addr == `TBP_OFS_DATA) |->
        rdata[3:2] == $past(pin_oe & pin_out | ~pin_oe & pin_in))
        else $error("data read");
    a_rd_top: assert property ($past(rd) |-> rdata[7:6] == 2'h0)
        else $error("upper bits");
endmodule
bind tbp_port tbp_props #(.AW(AW)) props_u (.clk(clk), .ce(ce),
    .sys_rst(sys_rst), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .reset_pulldown_disable_option(reset_pulldown_disable_option),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pulldown_en(pin_pulldown_en));

// File: test/test_tbp_port.sv
// Self-checking bench for the two-bit port
`include "tbp_map.vh"
module test_tbp_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, opt = 0, wr = 0, rd = 0, ce = 1;
    logic [7:0] addr = 0, wdata = 0;
    logic [1:0] ext_en = 0, ext_val = 0;
    wire [7:0] rdata;
    wire [1:0] pin_in, pin_out, pin_oe, pin_pd;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    tbp_port dut_u (.clk(clk), .ce(ce), .sys_rst(sys_rst),
        .reset_pulldown_disable_option(opt), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pulldown_en(pin_pd));
    tbp_board board_u (.clk(clk), .out(pin_out), .oe(pin_oe), .pd(pin_pd),
        .ext_en(ext_en), .ext_val(ext_val), .pin(pin_in));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task do_rst(input logic o);
        @(posedge clk) sys_rst <= 1;
        opt <= o;
        repeat (4) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk) #1;
    endtask
    task w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk) wr <= 0;
        #1;
    endtask
    task r(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) rd <= 1;
        addr <= a;
        @(posedge clk) rd <= 0;
        #1 chk(rdata, e);
    endtask
    // Hang guard, far above the sequence length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            wrap_up;
        end
    end
    initial begin
        do_rst(1'b0);
        chk({6'h0, pin_pd}, 8'h03);
        r(`TBP_OFS_DIR, 8'h00);
        ext_en <= 2'h3;
        ext_val <= 2'h2;
        r(`TBP_OFS_DATA, 8'h08);
        w(`TBP_OFS_DATA, 8'hff);
        w(`TBP_OFS_DIR, 8'h0c);
        r(`TBP_OFS_DATA, 8'h0c);
        w(`TBP_OFS_DATA, 8'h04);
        w(`TBP_OFS_DIR, 8'h08);
        chk({4'h0, pin_oe, pin_out}, 8'h08);
        r(`TBP_OFS_DATA, 8'h00);
        w(`TBP_OFS_DIR, 8'hff);
        r(`TBP_OFS_DIR, 8'h3f);
        w(`TBP_OFS_DATA, 8'hf3);
        r(`TBP_OFS_DATA, 8'h33);
        w(`TBP_OFS_DIR, 8'h00);
        w(`TBP_OFS_PULL, 8'h04);
        chk({6'h0, pin_pd}, 8'h02);
        r(`TBP_OFS_PULL, 8'h00);
        r(8'h22, 8'h00);
        // Enable low: the write must be lost
        ce <= 0;
        w(`TBP_OFS_DIR, 8'h0c);
        ce <= 1;
        r(`TBP_OFS_DIR, 8'h00);
        w(`TBP_OFS_DATA, 8'h08);
        do_rst(1'b1);
        chk({6'h0, pin_pd}, 8'h00);
        w(`TBP_OFS_DIR, 8'h0c);
        r(`TBP_OFS_DATA, 8'h08);
        wrap_up;
    end
endmodule
